// [verilog/ldu_long_divide_unit.sv]
// Long word divide unit: decode, sequencing, flags, trap and register port
//
// Notes on behaviour
// RULE_01: unsigned divide; source operand never modified
// RULE_02: unsigned fits: store results, clear V,S
// RULE_03: zero divisor: keep registers, Z=V=1, trap
// RULE_04: unsigned too large: keep registers, V, trap
// RULE_05: unsigned Z from quotient or divisor; H kept
// RULE_06: signed divide; remainder follows dividend sign
// RULE_07: signed fits: store results, S,Z from quotient
// RULE_08: signed out of range: keep, V, trap
// RULE_09: signed S cleared when V set
// RULE_10: register form ED then 11 rr 011
// RULE_11: immediate form FD ED 11 111 011
// RULE_12: direct form DD ED 11 011 011
// RULE_13: indexed form FD ED 11 xy 011
// RULE_14: relative DD..111, low indirect DD..001 forms
// RULE_15: signed uses final field 010
// RULE_16: only listed source modes are accepted
// RULE_17: flag layout fixed; carry and N untouched
`timescale 1ns/1ps
`default_nettype none
`include "ldu_regs.svh"

module ldu_long_divide_unit
	import ldu_pkg::*;
(
	input  wire logic        i_core_clk,
	input  wire logic        i_reset,
	input  wire logic        i_clk_en,
	// Instruction from the decoder and operands from operand fetch
	input  wire logic        i_req,
	input  wire logic        i_prefix_valid,
	input  wire logic [7:0]  i_prefix,
	input  wire logic [7:0]  i_escape,
	input  wire logic [7:0]  i_opcode,
	input  wire logic [15:0] i_source,
	input  wire logic [15:0] i_high_word,
	input  wire logic [15:0] i_low_word,
	input  wire logic [7:0]  i_flags,
	// Results towards the register file and exception unit
	output logic             o_busy,
	output logic             o_done,
	output logic             o_write,
	output logic [15:0]      o_quotient,
	output logic [15:0]      o_remainder,
	output logic [7:0]       o_flags,
	output logic             o_trap,
	output logic             o_illegal,
	output logic [2:0]       o_mode,
	// Register port
	input  wire logic [1:0]  i_reg_addr,
	input  wire logic [7:0]  i_reg_wdata,
	input  wire logic        i_reg_wr,
	input  wire logic        i_reg_rd,
	output logic [7:0]       o_reg_rdata,
	output logic             o_irq
);

	// ==========================================================
	// Helpers

	// Picks the legal form for an instruction, or reports none
	function automatic ldu_dec_t decode(input logic pv, input logic [7:0] pre,
		input logic [7:0] esc, input logic [7:0] op);
		ldu_dec_t   d;
		logic [2:0] f;
		d = '{ok: 1'b0, sgn: 1'b0, mode: LDU_MODE_NONE};
		f = op[5:3];
		if (esc == `LDU_ESC_BYTE && op[7:6] == `LDU_OP_TOP && op[2:1] == `LDU_OP_CLASS)
		begin
			// RULE_15: low bit 0 selects signed
			d.sgn = ~op[0];
			if (!pv)
			begin
				// RULE_10: pair select odd codes
				if (f[0])
				begin
					d.ok = 1'b1;
					d.mode = LDU_MODE_REG;
				end
			end
			else if (pre == `LDU_PRE_FIRST)
			begin
				// RULE_11: immediate source
				if (f == `LDU_FLD_IMM)
				begin
					d.ok = 1'b1;
					d.mode = LDU_MODE_IMM;
				end
				// RULE_13: index select field
				else if (f == `LDU_FLD_IDX_FIRST || f == `LDU_FLD_IDX_SEC)
				begin
					d.ok = 1'b1;
					d.mode = LDU_MODE_INDEX;
				end
			end
			else if (pre == `LDU_PRE_SECOND)
			begin
				// RULE_12: direct address source
				if (f == `LDU_FLD_DIRECT)
				begin
					d.ok = 1'b1;
					d.mode = LDU_MODE_DIRECT;
				end
				// RULE_14: relative and low indirect
				else if (f == `LDU_FLD_REL)
				begin
					d.ok = 1'b1;
					d.mode = LDU_MODE_REL;
				end
				else if (f == `LDU_FLD_LOW_IND)
				begin
					d.ok = 1'b1;
					d.mode = LDU_MODE_LOW_IND;
				end
			end
		end
		// RULE_16: anything else is refused
		if (!d.ok)
			d.mode = LDU_MODE_NONE;
		return d;
	endfunction

	// Two's complement negate when asked; used for operands and results
	function automatic logic [31:0] cond_neg(input logic [31:0] v, input logic neg);
		return neg ? 32'(~v + 32'h0000_0001) : v;
	endfunction

	// ==========================================================
	// State

	typedef struct packed {
		ldu_state_t  st;
		logic        sgn;
		logic        neg_q;
		logic        neg_r;
		logic [7:0]  flags_in;
		ldu_mode_t   mode;
		logic        busy;
		logic        done;
		logic        write;
		logic [15:0] quo;
		logic [15:0] rem;
		logic [7:0]  flags;
		logic        trap;
		logic        illegal;
		logic        start;
		logic [31:0] dvd;
		logic [15:0] dsr;
		logic [2:0]  status;
		logic [2:0]  mask;
		logic [7:0]  rdata;
		logic        irq;
	} ldu_top_t;

	ldu_top_t s_q;
	ldu_top_t s_d;
	ldu_dec_t dec;
	logic [31:0] mag_q;
	logic [31:0] sq;
	logic [15:0] mag_r;
	logic        fits;
	logic [2:0]  ev;

	ldu_div_if div_bus ();

	ldu_div_core u_core (
		.i_core_clk (i_core_clk),
		.i_reset    (i_reset),
		.i_clk_en   (i_clk_en),
		.bus        (div_bus.core)
	);

	assign div_bus.start    = s_q.start;
	assign div_bus.dividend = s_q.dvd;
	assign div_bus.divisor  = s_q.dsr;

	// ==========================================================
	// Sequencer, flags and register port
	always_comb
	begin
		s_d = s_q;
		s_d.done = 1'b0;
		s_d.write = 1'b0;
		s_d.trap = 1'b0;
		s_d.illegal = 1'b0;
		s_d.start = 1'b0;
		ev = '0;
		dec = decode(i_prefix_valid, i_prefix, i_escape, i_opcode);
		mag_q = div_bus.quotient;
		sq = cond_neg(mag_q, s_q.neg_q);
		mag_r = div_bus.remainder;
		// Negative side reaches one further than positive
		fits = s_q.neg_q ? (mag_q <= `LDU_SQ_NEG_MAX) : (mag_q <= `LDU_SQ_POS_MAX);

		unique case (s_q.st)
			LDU_ST_IDLE:
			begin
				if (i_req)
				begin
					s_d.mode = dec.mode;
					s_d.sgn = dec.sgn;
					s_d.flags_in = i_flags;
					if (!dec.ok)
					begin
						s_d.illegal = 1'b1;
						ev[`LDU_EV_ILLEGAL] = 1'b1;
					end
					else if (i_source == '0)
					begin
						// RULE_03: zero divisor outcome
						s_d.flags = i_flags;
						s_d.flags[`LDU_FLAG_Z] = 1'b1;
						s_d.flags[`LDU_FLAG_V] = 1'b1;
						s_d.flags[`LDU_FLAG_S] = 1'b0;
						s_d.trap = 1'b1;
						s_d.done = 1'b1;
						ev[`LDU_EV_TRAP] = 1'b1;
						ev[`LDU_EV_DONE] = 1'b1;
					end
					else
					begin
						// RULE_01: unsigned operands pass untouched
						// RULE_06: signed operands go in as magnitudes
						s_d.neg_r = dec.sgn & i_high_word[15];
						s_d.neg_q = dec.sgn & (i_high_word[15] ^ i_source[15]);
						s_d.dvd = cond_neg({i_high_word, i_low_word}, dec.sgn & i_high_word[15]);
						s_d.dsr = 16'(cond_neg({16'h0000, i_source}, dec.sgn & i_source[15]));
						s_d.start = 1'b1;
						s_d.busy = 1'b1;
						s_d.st = LDU_ST_RUN;
					end
				end
			end
			LDU_ST_RUN:
			begin
				if (div_bus.done)
					s_d.st = LDU_ST_FINISH;
			end
			LDU_ST_FINISH:
			begin
				s_d.st = LDU_ST_IDLE;
				s_d.busy = 1'b0;
				s_d.done = 1'b1;
				ev[`LDU_EV_DONE] = 1'b1;
				// RULE_17: carry, N, H and spare bits pass through
				s_d.flags = s_q.flags_in;
				s_d.flags[`LDU_FLAG_S] = 1'b0;
				if (!s_q.sgn)
				begin
					// RULE_04: unsigned quotient too wide
					if (mag_q[31:16] != '0)
					begin
						s_d.flags[`LDU_FLAG_V] = 1'b1;
						s_d.flags[`LDU_FLAG_Z] = 1'b0;
						s_d.trap = 1'b1;
						ev[`LDU_EV_TRAP] = 1'b1;
					end
					else
					begin
						// RULE_02: store results
						// RULE_05: zero from quotient
						s_d.write = 1'b1;
						s_d.quo = mag_q[15:0];
						s_d.rem = mag_r;
						s_d.flags[`LDU_FLAG_V] = 1'b0;
						s_d.flags[`LDU_FLAG_Z] = (mag_q[15:0] == '0);
					end
				end
				else if (!fits)
				begin
					// RULE_08: signed out of range
					// RULE_09: sign cleared with overflow
					s_d.flags[`LDU_FLAG_V] = 1'b1;
					s_d.flags[`LDU_FLAG_Z] = 1'b0;
					s_d.trap = 1'b1;
					ev[`LDU_EV_TRAP] = 1'b1;
				end
				else
				begin
					// RULE_07: signed store and flags
					// RULE_06: remainder takes dividend sign
					s_d.write = 1'b1;
					s_d.quo = sq[15:0];
					s_d.rem = 16'(cond_neg({16'h0000, mag_r}, s_q.neg_r));
					s_d.flags[`LDU_FLAG_V] = 1'b0;
					// RULE_09: sign from quotient
					s_d.flags[`LDU_FLAG_S] = sq[15];
					s_d.flags[`LDU_FLAG_Z] = (sq[15:0] == '0);
				end
			end
		endcase

		// Read data appear the cycle after the strobe
		s_d.rdata = '0;
		if (i_reg_rd)
		begin
			unique case (i_reg_addr)
				`LDU_ADDR_STATUS: s_d.rdata = {5'h00, s_q.status};
				`LDU_ADDR_MASK:   s_d.rdata = {5'h00, s_q.mask};
				`LDU_ADDR_LAST:   s_d.rdata = {s_q.busy, 4'h0, s_q.mode};
				default:          s_d.rdata = '0;
			endcase
		end
		if (i_reg_wr && i_reg_addr == `LDU_ADDR_MASK)
			s_d.mask = i_reg_wdata[2:0];
		// Read clears status, but an event in the same cycle survives
		if (i_reg_rd && i_reg_addr == `LDU_ADDR_STATUS)
			s_d.status = ev;
		else
			s_d.status = s_q.status | ev;
		s_d.irq = |(s_d.status & s_d.mask);
	end

	// ==========================================================
	// State register; clock enable freezes everything
	always_ff @(posedge i_core_clk)
	begin
		if (i_reset)
		begin
			s_q <= '0;
			s_q.st <= LDU_ST_IDLE;
			s_q.mode <= LDU_MODE_NONE;
		end
		else if (i_clk_en)
			s_q <= s_d;
	end

	// ==========================================================
	// Outputs, all straight from the state register
	assign o_busy      = s_q.busy;
	assign o_done      = s_q.done;
	assign o_write     = s_q.write;
	assign o_quotient  = s_q.quo;
	assign o_remainder = s_q.rem;
	assign o_flags     = s_q.flags;
	assign o_trap      = s_q.trap;
	assign o_illegal   = s_q.illegal;
	assign o_mode      = s_q.mode;
	assign o_reg_rdata = s_q.rdata;
	assign o_irq       = s_q.irq;

endmodule

`default_nettype wire

// [verilog/ldu_regs.svh]
// Constants for the long word divide unit: opcodes, fields, flags, register map
`ifndef LDU_REGS_SVH
`define LDU_REGS_SVH

// Instruction bytes
`define LDU_ESC_BYTE      8'hED
`define LDU_PRE_FIRST     8'hFD
`define LDU_PRE_SECOND    8'hDD
`define LDU_OP_TOP        2'h3
`define LDU_OP_CLASS      2'h1

// Middle three-bit field of the last opcode byte
`define LDU_FLD_IMM       3'h7
`define LDU_FLD_REL       3'h7
`define LDU_FLD_DIRECT    3'h3
`define LDU_FLD_LOW_IND   3'h1
`define LDU_FLD_IDX_FIRST 3'h1
`define LDU_FLD_IDX_SEC   3'h3

// Flag byte positions
`define LDU_FLAG_S        3'd7
`define LDU_FLAG_Z        3'd6
`define LDU_FLAG_V        3'd2

// Signed quotient limits, as magnitudes
`define LDU_SQ_NEG_MAX    32'h0000_8000
`define LDU_SQ_POS_MAX    32'h0000_7FFF

// Divider step count
`define LDU_STEPS         6'h20

// Register port
`define LDU_ADDR_STATUS   2'h0
`define LDU_ADDR_MASK     2'h1
`define LDU_ADDR_LAST     2'h2
`define LDU_EV_TRAP       2'd0
`define LDU_EV_DONE       2'd1
`define LDU_EV_ILLEGAL    2'd2

`endif

// [verilog/ldu_pkg.sv]
// Types shared by the long word divide unit
package ldu_pkg;

	typedef enum logic [2:0] {
		LDU_MODE_NONE,
		LDU_MODE_REG,
		LDU_MODE_IMM,
		LDU_MODE_DIRECT,
		LDU_MODE_INDEX,
		LDU_MODE_REL,
		LDU_MODE_LOW_IND
	} ldu_mode_t;

	typedef enum logic [1:0] {
		LDU_ST_IDLE,
		LDU_ST_RUN,
		LDU_ST_FINISH
	} ldu_state_t;

	typedef struct packed {
		logic      ok;
		logic      sgn;
		ldu_mode_t mode;
	} ldu_dec_t;

endpackage

// [verilog/ldu_div_if.sv]
// Handshake between the divide unit sequencer and its iterative divider core
`timescale 1ns/1ps
`default_nettype none

interface ldu_div_if;
	logic        start;
	logic [31:0] dividend;
	logic [15:0] divisor;
	logic        done;
	logic [31:0] quotient;
	logic [15:0] remainder;

	modport ctrl (output start, output dividend, output divisor,
		input done, input quotient, input remainder);
	modport core (input start, input dividend, input divisor,
		output done, output quotient, output remainder);
endinterface

`default_nettype wire

// [verilog/ldu_div_core.sv]
// Restoring 32 by 16 unsigned divider, one quotient bit per cycle
`timescale 1ns/1ps
`default_nettype none
`include "ldu_regs.svh"

module ldu_div_core
	import ldu_pkg::*;
(
	input  wire logic i_core_clk,
	input  wire logic i_reset,
	input  wire logic i_clk_en,
	ldu_div_if.core   bus
);

	typedef struct packed {
		logic [5:0]  cnt;
		logic [15:0] rem;
		logic [31:0] quo;
		logic [15:0] dsr;
		logic        done;
	} ldu_core_t;

	ldu_core_t s_q;
	ldu_core_t s_d;
	logic [16:0] shifted;

	// ==========================================================
	// Step logic
	always_comb
	begin
		s_d = s_q;
		s_d.done = 1'b0;
		shifted = {s_q.rem, s_q.quo[31]};
		if (bus.start)
		begin
			s_d.cnt = `LDU_STEPS;
			s_d.rem = '0;
			s_d.quo = bus.dividend;
			s_d.dsr = bus.divisor;
		end
		else if (s_q.cnt != '0)
		begin
			// Remainder stays below the divisor, so 16 bits hold it
			if (shifted >= {1'b0, s_q.dsr})
			begin
				s_d.rem = 16'(shifted - {1'b0, s_q.dsr});
				s_d.quo = {s_q.quo[30:0], 1'b1};
			end
			else
			begin
				s_d.rem = shifted[15:0];
				s_d.quo = {s_q.quo[30:0], 1'b0};
			end
			s_d.cnt = 6'(s_q.cnt - 6'h01);
			s_d.done = (s_q.cnt == 6'h01);
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge i_core_clk)
	begin
		if (i_reset)
			s_q <= '0;
		else if (i_clk_en)
			s_q <= s_d;
	end

	assign bus.done      = s_q.done;
	assign bus.quotient  = s_q.quo;
	assign bus.remainder = s_q.rem;

endmodule

`default_nettype wire

// [bench/ldu_exc_model.sv]
// Exception unit stand-in: counts division traps taken
`timescale 1ns/1ps
`default_nettype none
module ldu_exc_model (
	input  wire logic       i_core_clk,
	input  wire logic       i_reset,
	input  wire logic       i_trap,
	input  wire logic       i_done,
	output logic      [7:0] o_traps
);
	// A trap without a finished instruction would be lost, so only paired pulses count
	always_ff @(posedge i_core_clk)
	begin
		if (i_reset)
			o_traps <= 8'h00;
		else if (i_trap && i_done)
			o_traps <= o_traps + 8'h01;
	end
endmodule
`default_nettype wire

// [bench/ldu_long_divide_unit_sva.sv]
// Port checks for the long word divide unit
`timescale 1ns/1ps
`default_nettype none
module ldu_chk_sva (
	input wire logic        i_core_clk,
	input wire logic        i_reset,
	input wire logic        i_clk_en,
	input wire logic        i_req,
	input wire logic [15:0] i_source,
	input wire logic        o_busy,
	input wire logic        o_done,
	input wire logic        o_write,
	input wire logic [15:0] o_quotient,
	input wire logic [7:0]  o_flags,
	input wire logic        o_trap,
	input wire logic        o_illegal
);
	// ========================================
	// Checks, all in the core clock domain
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_reset);
	logic take;
	// Request accepted by an idle unit
	assign take = i_req && !o_busy && i_clk_en;
	property p_zero_div; take && i_source == 16'h0000 |=> o_illegal || (o_done && o_trap && o_flags[6]); endproperty
	a_zero_div: assert property (p_zero_div) else $error("zero divisor not trapped at once");
	property p_latency; take && i_source != 16'h0000 |=> o_illegal or (o_busy ##34 o_done); endproperty
	a_latency: assert property (p_latency) else $error("divide did not finish on time");
	property p_trap; o_trap |-> o_done && !o_write && o_flags[2] && !o_flags[7]; endproperty
	a_trap: assert property (p_trap) else $error("trap with wrong flags or a write");
	property p_write; o_write |-> o_done && !o_flags[2] && (o_flags[6] == (o_quotient == 16'h0000)); endproperty
	a_write: assert property (p_write) else $error("write with wrong flags");
	property p_vflag; o_done |-> o_trap == o_flags[2]; endproperty
	a_vflag: assert property (p_vflag) else $error("overflow flag and trap disagree");
	property p_busy_end; $fell(o_busy) && !$past(i_reset) |-> o_done; endproperty
	a_busy_end: assert property (p_busy_end) else $error("busy ended without done");
	property p_illegal; o_illegal |-> !o_done && !o_write && !o_busy; endproperty
	a_illegal: assert property (p_illegal) else $error("illegal form went on to execute");
	property p_ignore; o_busy && i_req && i_source == 16'h0000 |=> !(o_done && o_flags[6] && o_flags[2]); endproperty
	a_ignore: assert property (p_ignore) else $error("request while busy was taken");
endmodule
bind ldu_long_divide_unit ldu_chk_sva ldu_chk_sva_inst (.i_core_clk, .i_reset, .i_clk_en, .i_req, .i_source,
	.o_busy, .o_done, .o_write, .o_quotient, .o_flags, .o_trap, .o_illegal);
`default_nettype wire

// [bench/testbench.sv]
// Self-checking bench for the long word divide unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        i_core_clk = 1'b0, i_reset = 1'b1, i_clk_en = 1'b1, i_req = 1'b0, i_prefix_valid = 1'b0;
	logic        i_reg_wr = 1'b0, i_reg_rd = 1'b0;
	logic [7:0]  i_prefix = 8'h00, i_escape = 8'h00, i_opcode = 8'h00, i_flags = 8'h00, i_reg_wdata = 8'h00;
	logic [15:0] i_source = 16'h0000, i_high_word = 16'h0000, i_low_word = 16'h0000;
	logic [1:0]  i_reg_addr = 2'h0;
	logic        o_busy, o_done, o_write, o_trap, o_illegal, o_irq;
	logic [15:0] o_quotient, o_remainder;
	logic [7:0]  o_flags, o_reg_rdata, traps;
	logic [2:0]  o_mode;
	int          n_fail = 0, checked = 0, cyc = 0, ntrap = 0, nt = 0;

	ldu_long_divide_unit ldu_long_divide_unit_inst (.i_core_clk, .i_reset, .i_clk_en, .i_req, .i_prefix_valid,
		.i_prefix, .i_escape, .i_opcode, .i_source, .i_high_word, .i_low_word, .i_flags, .o_busy, .o_done, .o_write,
		.o_quotient, .o_remainder, .o_flags, .o_trap, .o_illegal, .o_mode, .i_reg_addr, .i_reg_wdata, .i_reg_wr,
		.i_reg_rd, .o_reg_rdata, .o_irq);
	ldu_exc_model ldu_exc_model_inst (.i_core_clk, .i_reset, .i_trap(o_trap), .i_done(o_done), .o_traps(traps));

	// ========================================
	// Clock and hang guard; the tests need about 650 cycles
	always #10 i_core_clk = ~i_core_clk;
	always @(posedge i_core_clk)
	begin
		cyc++;
		if (cyc == 4000)
		begin
			n_fail++;
			wrap_up();
		end
	end

	// ========================================
	// Shared tasks
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wrap_up;
		$display("Comparisons %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge i_core_clk);
		i_reg_wr <= 1'b1;
		i_reg_addr <= a;
		i_reg_wdata <= d;
		@(posedge i_core_clk);
		i_reg_wr <= 1'b0;
	endtask
	task automatic reg_rd(input string what, input logic [1:0] a, input logic [7:0] e);
		@(posedge i_core_clk);
		i_reg_rd <= 1'b1;
		i_reg_addr <= a;
		@(posedge i_core_clk);
		i_reg_rd <= 1'b0;
		#1;
		check(what, o_reg_rdata, e);
	endtask
	// Interrupt level changes on the same edge as the status; the check waits two edges
	task automatic irq_is(input logic e);
		repeat (2) @(posedge i_core_clk);
		#1;
		check("irq", o_irq, e);
	endtask
	// One instruction; poke holds the request a second cycle with a zero divisor while busy
	task automatic run(input logic pv, input logic [7:0] pre, esc, op, input logic [15:0] src, input logic [31:0] dvd,
		input logic [2:0] mode, input logic poke);
		longint a, b, q = 0, r = 0;
		logic ov, z, s;
		logic [7:0] fin;
		int k = 0;
		fin = dvd[7:0] ^ src[7:0];
		@(posedge i_core_clk);
		i_req <= 1'b1;
		i_prefix_valid <= pv;
		i_prefix <= pre;
		i_escape <= esc;
		i_opcode <= op;
		i_source <= src;
		{i_high_word, i_low_word} <= dvd;
		i_flags <= fin;
		@(posedge i_core_clk);
		if (poke)
		begin
			i_source <= 16'h0000;
			@(posedge i_core_clk);
			k = 1;
		end
		i_req <= 1'b0;
		#1;
		// Only a legal request with a nonzero divisor starts the iterative core
		check("busy", o_busy, mode != 3'h0 && src != 16'h0000);
		while (!(o_done === 1'b1 || o_illegal === 1'b1) && k < 40)
		begin
			@(posedge i_core_clk);
			#1;
			k++;
		end
		// Truncating division leaves the remainder on the dividend's side
		a = op[0] ? longint'(dvd) : longint'($signed(dvd));
		b = op[0] ? longint'(src) : longint'($signed(src));
		if (b != 0)
		begin
			q = a / b;
			r = a % b;
		end
		ov = (b == 0) || (op[0] ? q > 65535 : (q < -32768 || q > 32767));
		z = (b == 0) || (!ov && q == 0);
		s = !ov && q < 0;
		check("illegal", o_illegal, mode == 3'h0);
		if (mode != 3'h0)
		begin
			ntrap += ov;
			// Take edge N, result edge N+35: load, 32 steps, finish, report
			check("latency", k, (b == 0) ? 0 : 35);
			check("done", o_done, 1'b1);
			check("busy end", o_busy, 1'b0);
			check("trap", o_trap, ov);
			check("write", o_write, !ov);
			check("flags", o_flags, {s, z, fin[5:3], ov, fin[1:0]});
			check("mode", o_mode, mode);
			if (!ov)
			begin
				check("quotient", o_quotient, q[15:0]);
				check("remainder", o_remainder, r[15:0]);
			end
		end
		nt++;
		$display("Divide test %0d finished", nt);
	endtask

	// ========================================
	// Main sequence
	initial
	begin
		repeat (10) @(posedge i_core_clk);
		i_reset <= 1'b0;
		reg_rd("status", 2'h0, 8'h00);
		reg_rd("mask", 2'h1, 8'h00);
		reg_rd("last", 2'h2, 8'h00);
		reg_wr(2'h1, 8'h07);
		reg_rd("mask", 2'h1, 8'h07);
		for (int i = 0; i < 4; i++)
			run(0, 8'h00, 8'hED, {2'b11, 2'(i), 4'b1011}, 16'h0006, 32'h0000_0022, 3'h1, 0);
		run(1, 8'hFD, 8'hED, 8'hFB, 16'h0000, 32'h1234_5678, 3'h2, 0);
		run(1, 8'hDD, 8'hED, 8'hDB, 16'h0001, 32'h0001_0000, 3'h3, 0);
		run(1, 8'hFD, 8'hED, 8'hCB, 16'h0002, 32'h0001_FFFF, 3'h4, 1);
		run(1, 8'hFD, 8'hED, 8'hDB, 16'hFFFF, 32'h0000_FFFE, 3'h4, 0);
		run(1, 8'hDD, 8'hED, 8'hFB, 16'h8001, 32'h7FFF_0000, 3'h5, 0);
		run(1, 8'hDD, 8'hED, 8'hCB, 16'h1234, 32'h0000_0000, 3'h6, 0);
		run(0, 8'h00, 8'hED, 8'hCA, 16'h0006, 32'hFFFF_FFDE, 3'h1, 0);
		run(1, 8'hFD, 8'hED, 8'hFA, 16'hFFFF, 32'h0000_8000, 3'h2, 0);
		run(1, 8'hDD, 8'hED, 8'hDA, 16'hFFFF, 32'hFFFF_8000, 3'h3, 0);
		run(1, 8'hFD, 8'hED, 8'hDA, 16'hFFF9, 32'h0000_0031, 3'h4, 0);
		run(1, 8'hFD, 8'hED, 8'hCA, 16'hFFFD, 32'h0000_0007, 3'h4, 0);
		run(1, 8'hDD, 8'hED, 8'hFA, 16'h0000, 32'h0000_0005, 3'h5, 0);
		run(1, 8'hDD, 8'hED, 8'hCA, 16'h0003, 32'h7FFF_FFFF, 3'h6, 0);
		run(1, 8'hFD, 8'hED, 8'hEB, 16'h0001, 32'h0000_0001, 3'h0, 0);
		run(1, 8'hDD, 8'hED, 8'hEB, 16'h0001, 32'h0000_0001, 3'h0, 0);
		run(0, 8'h00, 8'hED, 8'hCC, 16'h0001, 32'h0000_0001, 3'h0, 0);
		run(0, 8'h00, 8'hED, 8'hC3, 16'h0001, 32'h0000_0001, 3'h0, 0);
		run(0, 8'h00, 8'hCB, 8'hCB, 16'h0001, 32'h0000_0001, 3'h0, 0);
		check("traps", traps, ntrap);
		// Status collects every event, mask gates the interrupt
		irq_is(1);
		reg_rd("status", 2'h0, 8'h07);
		reg_rd("status", 2'h0, 8'h00);
		irq_is(0);
		reg_wr(2'h1, 8'h04);
		run(0, 8'h00, 8'hED, 8'hEB, 16'h0100, 32'h00FF_FF00, 3'h1, 0);
		irq_is(0);
		reg_wr(2'h0, 8'hFF);
		reg_rd("status", 2'h0, 8'h02);
		reg_rd("unmapped", 2'h3, 8'h00);
		reg_rd("last", 2'h2, 8'h01);
		run(0, 8'h00, 8'hED, 8'hC3, 16'h0001, 32'h0000_0001, 3'h0, 0);
		irq_is(1);
		$display("Register test finished");
		wrap_up();
	end
endmodule
`default_nettype wire
